// >>> ebb_defs.svh
// constants for the event block builder: offsets, fields, reset values
// ==========================================================
`ifndef EBB_DEFS_SVH
`define EBB_DEFS_SVH
// ==========================================================
// register offsets
`define EBB_OFS_CTRL 8'h00
`define EBB_OFS_ID 8'h04
`define EBB_OFS_STATUS 8'h08
`define EBB_OFS_SYNC_DIN 8'h10
`define EBB_OFS_SYNC_STAT 8'h14
`define EBB_OFS_SLEN_DIN 8'h18
`define EBB_OFS_SLEN_STAT 8'h1C
`define EBB_OFS_ASYNC_DIN 8'h20
`define EBB_OFS_ASYNC_STAT 8'h24
`define EBB_OFS_ALEN_DIN 8'h28
`define EBB_OFS_ALEN_STAT 8'h2C
// ==========================================================
// control fields and reset values
`define EBB_CTRL_RESET 0
`define EBB_CTRL_PAUSE 1
`define EBB_CTRL_DDR 2
`define EBB_CTRL_DMA_RSTN 3
`define EBB_CTRL_FPGA_EN 8
`define EBB_CTRL_SYNC_EN 9
`define EBB_CTRL_ASYNC_EN 10
`define EBB_CTRL_MASK 32'h0000070F
`define EBB_CTRL_RST 32'h00000000
`define EBB_ID_MASK 32'h000000FF
`define EBB_STAT_FULL 31
// ==========================================================
// FIFO geometry and framing words (framing values are arbitrary)
`define EBB_FIFO_DEPTH 512
`define EBB_FIFO_AW 9
`define EBB_FIFO_LW 10
`define EBB_FIFO_SD 0
`define EBB_FIFO_SL 1
`define EBB_FIFO_AD 2
`define EBB_FIFO_AL 3
`define EBB_MSG_TYPE 16'h0001
`define EBB_HDR_TAG 32'h00000008
`define EBB_STATUS_TAG 16'h0F10
`define EBB_TRIG_TAG 16'h0F20
`endif

// >>> ebb_pkg.sv
// types shared by the event block builder files
package ebb_pkg;
  typedef enum logic [3:0] {
    EBB_IDLE = 4'h0,
    EBB_GET_TB = 4'h1,
    EBB_GET_FPGA = 4'h2,
    EBB_GET_SYNC = 4'h3,
    EBB_HDR_NET = 4'h4,
    EBB_HDR_RO = 4'h5,
    EBB_FPGA = 4'h6,
    EBB_SYNC = 4'h7,
    EBB_ASYNC = 4'h8,
    EBB_ACK = 4'h9
  } ebb_main_t;
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } ebb_word_t;
endpackage

// >>> ebb_word_fifo.sv
// word FIFO with a registered read port
`timescale 1ns/1ps
`include "ebb_defs.svh"
module ebb_word_fifo
  import ebb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic clr,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output logic full,
  output logic empty,
  output logic [`EBB_FIFO_LW-1:0] level
);
  typedef struct packed {
    logic [`EBB_FIFO_AW-1:0] wp;
    logic [`EBB_FIFO_AW-1:0] rp;
    logic [`EBB_FIFO_LW-1:0] cnt;
    logic avail;
    logic [31:0] rdat;
  } ebb_fifo_st_t;
  ebb_fifo_st_t q;
  ebb_fifo_st_t d;
  logic [31:0] mem [`EBB_FIFO_DEPTH];
  logic do_wr;
  logic do_rd;
  assign full = (q.cnt == `EBB_FIFO_LW'(`EBB_FIFO_DEPTH));
  assign empty = !q.avail;
  assign level = q.cnt;
  assign rd_data = q.rdat;
  assign do_wr = wr_en && !full;
  assign do_rd = rd_en && q.avail;
  always_comb
  begin
    d = q;
    d.rdat = mem[q.rp];
    // head is offered a cycle after its write so the read register is fresh
    d.avail = (q.cnt != '0) && !do_rd;
    if (do_wr)
      d.wp = q.wp + 1'b1;
    if (do_rd)
      d.rp = q.rp + 1'b1;
    d.cnt = q.cnt + `EBB_FIFO_LW'(do_wr) - `EBB_FIFO_LW'(do_rd);
    if (clr)
    begin
      d.wp = '0;
      d.rp = '0;
      d.cnt = '0;
      d.avail = 1'b0;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (ce && do_wr && !clr)
      mem[q.wp] <= wr_data;
  end
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else if (ce)
      q <= d;
  end
endmodule // ebb_word_fifo

// >>> ebb_builder.sv
// event block builder: register port, sequencer and output framing
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "ebb_defs.svh"
module ebb_builder
  import ebb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic tb_len_valid,
  input wire logic [31:0] tb_len,
  output logic tb_len_ready,
  input wire ebb_word_t tb_word,
  output logic tb_word_ready,
  input wire logic fpga_len_valid,
  input wire logic [31:0] fpga_len,
  output logic fpga_len_ready,
  input wire ebb_word_t fpga_word,
  output logic fpga_word_ready,
  input wire logic net_full,
  input wire logic net_ready,
  output ebb_word_t net_out,
  output logic tb_ack,
  output logic ddr_buffer_enable,
  output logic ddr_dma_reset_n
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] rid;
    ebb_main_t ms;
    logic [3:0] hs;
    logic [3:0] cs;
    logic [3:0] ts;
    logic tdone;
    logic [31:0] tblen;
    logic [31:0] fplen;
    logic [31:0] sylen;
    logic [31:0] cnt;
    logic [31:0] blk;
    logic [9:0] pend;
    logic ack;
    ebb_word_t out;
    logic [31:0] rdata;
  } ebb_state_t;
  ebb_state_t q;
  ebb_state_t d;
  // ==========================================================
  // software FIFOs: sync data, sync length, async data, async length
  logic [3:0] push;
  logic [3:0] pop;
  logic [3:0] ffull;
  logic [3:0] fempty;
  logic [31:0] frd [4];
  logic [`EBB_FIFO_LW-1:0] flvl [4];
  logic sreset;
  assign sreset = q.ctrl[`EBB_CTRL_RESET];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_fifo
      ebb_word_fifo u_fifo (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .ce(ce),
        .clr(sreset),
        .wr_en(push[gi]),
        .wr_data(reg_wdata),
        .rd_en(pop[gi]),
        .rd_data(frd[gi]),
        .full(ffull[gi]),
        .empty(fempty[gi]),
        .level(flvl[gi])
      );
    end
  endgenerate
  // ==========================================================
  // control decode
  logic pause;
  logic fpga_en;
  logic sync_en;
  logic async_en;
  assign pause = q.ctrl[`EBB_CTRL_PAUSE];
  assign fpga_en = q.ctrl[`EBB_CTRL_FPGA_EN];
  assign sync_en = q.ctrl[`EBB_CTRL_SYNC_EN];
  assign async_en = q.ctrl[`EBB_CTRL_ASYNC_EN];
  assign ddr_buffer_enable = q.ctrl[`EBB_CTRL_DDR];
  // only forced low under soft reset; keeping it low without DDR is software's job
  assign ddr_dma_reset_n = q.ctrl[`EBB_CTRL_DMA_RSTN] && !sreset;
  assign reg_rdata = q.rdata;
  assign net_out = q.out;
  assign tb_ack = q.ack;
  // ==========================================================
  // framing lengths
  logic [31:0] trig_words;
  logic [31:0] ro_words;
  logic [31:0] blk_words;
  assign trig_words = q.tblen + 32'h00000004;
  assign ro_words = trig_words + q.fplen + q.sylen + 32'h00000002;
  assign blk_words = ro_words + 32'h00000005;
  // ==========================================================
  // next state
  logic can;
  logic emit;
  logic [31:0] ew;
  logic inc;
  logic dec;
  ebb_main_t after_ro;
  always_comb
  begin
    d = q;
    d.ack = 1'b0;
    d.rdata = '0;
    push = '0;
    pop = '0;
    inc = 1'b0;
    dec = 1'b0;
    emit = 1'b0;
    ew = '0;
    tb_len_ready = 1'b0;
    tb_word_ready = 1'b0;
    fpga_len_ready = 1'b0;
    fpga_word_ready = 1'b0;
    after_ro = sync_en ? EBB_SYNC : EBB_ACK;
    // a stalled engine holds the current word; full also covers an unconnected link
    can = (!q.out.valid || net_ready) && !net_full;
    if (net_ready)
      d.out.valid = 1'b0;
    // register writes; words pushed into a full FIFO are dropped
    if (reg_wr)
    begin
      case (reg_addr)
        `EBB_OFS_CTRL: d.ctrl = reg_wdata & `EBB_CTRL_MASK;
        `EBB_OFS_ID: d.rid = reg_wdata & `EBB_ID_MASK;
        `EBB_OFS_SYNC_DIN: push[`EBB_FIFO_SD] = 1'b1;
        `EBB_OFS_SLEN_DIN:
        begin
          push[`EBB_FIFO_SL] = 1'b1;
          dec = 1'b1;
        end
        `EBB_OFS_ASYNC_DIN: push[`EBB_FIFO_AD] = 1'b1;
        `EBB_OFS_ALEN_DIN: push[`EBB_FIFO_AL] = (reg_wdata != '0);
        default: ;
      endcase
    end
    // register reads, answered in the next cycle; unmapped reads zero
    if (reg_rd)
    begin
      case (reg_addr)
        `EBB_OFS_CTRL: d.rdata = q.ctrl;
        `EBB_OFS_ID: d.rdata = q.rid;
        `EBB_OFS_STATUS: d.rdata = {15'h0000, net_full, q.ms, q.hs, q.cs, q.ts};
        `EBB_OFS_SYNC_STAT:
          d.rdata = {ffull[`EBB_FIFO_SD], 21'h000000, flvl[`EBB_FIFO_SD]};
        `EBB_OFS_SLEN_STAT:
          d.rdata = {ffull[`EBB_FIFO_SL], 5'h00, q.pend, 6'h00, flvl[`EBB_FIFO_SL]};
        `EBB_OFS_ASYNC_STAT:
          d.rdata = {ffull[`EBB_FIFO_AD], 21'h000000, flvl[`EBB_FIFO_AD]};
        `EBB_OFS_ALEN_STAT:
          d.rdata = {ffull[`EBB_FIFO_AL], 21'h000000, flvl[`EBB_FIFO_AL]};
        default: d.rdata = '0;
      endcase
    end
    case (q.ms)
      EBB_IDLE:
      begin
        // new blocks start only here, so a pause always lands on a boundary
        if (!pause)
        begin
          if (async_en && !fempty[`EBB_FIFO_AL])
          begin
            pop[`EBB_FIFO_AL] = 1'b1;
            d.tblen = frd[`EBB_FIFO_AL];
            d.cnt = '0;
            d.ms = EBB_ASYNC;
          end
          else if (tb_len_valid)
            d.ms = EBB_GET_TB;
        end
      end
      EBB_GET_TB:
      begin
        tb_len_ready = 1'b1;
        inc = 1'b1;
        d.tblen = tb_len;
        d.fplen = '0;
        d.sylen = '0;
        d.cs = '0;
        d.ms = fpga_en ? EBB_GET_FPGA : (sync_en ? EBB_GET_SYNC : EBB_HDR_NET);
      end
      EBB_GET_FPGA:
      begin
        if (fpga_len_valid)
        begin
          fpga_len_ready = 1'b1;
          d.fplen = fpga_len;
          d.ms = sync_en ? EBB_GET_SYNC : EBB_HDR_NET;
        end
      end
      EBB_GET_SYNC:
      begin
        // building waits here until software supplies this block's length
        if (!fempty[`EBB_FIFO_SL])
        begin
          pop[`EBB_FIFO_SL] = 1'b1;
          d.sylen = frd[`EBB_FIFO_SL];
          d.ms = EBB_HDR_NET;
        end
      end
      EBB_HDR_NET:
      begin
        if (can)
        begin
          emit = 1'b1;
          d.cs = q.cs + 4'h1;
          case (q.cs)
            4'h0: ew = {`EBB_MSG_TYPE, blk_words[15:0] + 16'h0001};
            4'h1: ew = {q.blk[15:0], blk_words[15:0]};
            4'h2: ew = `EBB_HDR_TAG;
            4'h3: ew = '0;
            default:
            begin
              ew = '0;
              d.cs = 4'h4;
              d.hs = '0;
              d.ms = EBB_HDR_RO;
            end
          endcase
        end
      end
      EBB_HDR_RO:
      begin
        case (q.hs)
          4'h0:
          begin
            if (can)
            begin
              emit = 1'b1;
              ew = ro_words;
              d.hs = 4'h1;
            end
          end
          4'h1:
          begin
            if (can)
            begin
              emit = 1'b1;
              ew = {`EBB_STATUS_TAG, 8'h00, q.rid[7:0]};
              d.hs = 4'h2;
            end
          end
          4'h2:
          begin
            if (can)
            begin
              emit = 1'b1;
              ew = trig_words;
              d.hs = 4'h3;
              d.ts = '0;
              d.tdone = 1'b0;
              d.cnt = '0;
            end
          end
          default:
          begin
            if (!q.tdone)
            begin
              if (can)
              begin
                emit = 1'b1;
                case (q.ts)
                  4'h0: ew = {q.blk[15:0], q.tblen[15:0]};
                  4'h1: ew = {`EBB_TRIG_TAG, q.tblen[15:0]};
                  default: ew = '0;
                endcase
                if (q.ts == 4'h3)
                  d.tdone = 1'b1;
                else
                  d.ts = q.ts + 4'h1;
              end
            end
            else if (q.cnt == q.tblen)
            begin
              d.cnt = '0;
              d.ms = fpga_en ? EBB_FPGA : after_ro;
            end
            else if (can && tb_word.valid)
            begin
              tb_word_ready = 1'b1;
              emit = 1'b1;
              ew = tb_word.data;
              d.cnt = q.cnt + 32'h00000001;
            end
          end
        endcase
      end
      EBB_FPGA:
      begin
        if (q.cnt == q.fplen)
        begin
          d.cnt = '0;
          d.ms = after_ro;
        end
        else if (can && fpga_word.valid)
        begin
          fpga_word_ready = 1'b1;
          emit = 1'b1;
          ew = fpga_word.data;
          d.cnt = q.cnt + 32'h00000001;
        end
      end
      EBB_SYNC:
      begin
        if (q.cnt == q.sylen)
        begin
          d.cnt = '0;
          d.ms = EBB_ACK;
        end
        else if (can && !fempty[`EBB_FIFO_SD])
        begin
          pop[`EBB_FIFO_SD] = 1'b1;
          emit = 1'b1;
          ew = frd[`EBB_FIFO_SD];
          d.cnt = q.cnt + 32'h00000001;
        end
      end
      EBB_ASYNC:
      begin
        if (q.cnt == q.tblen)
        begin
          d.cnt = '0;
          d.ms = EBB_IDLE;
        end
        else if (can && !fempty[`EBB_FIFO_AD])
        begin
          pop[`EBB_FIFO_AD] = 1'b1;
          emit = 1'b1;
          ew = frd[`EBB_FIFO_AD];
          d.cnt = q.cnt + 32'h00000001;
        end
      end
      EBB_ACK:
      begin
        d.ack = 1'b1;
        d.blk = q.blk + 32'h00000001;
        d.ms = EBB_IDLE;
      end
      default: d.ms = EBB_IDLE;
    endcase
    if (emit)
    begin
      d.out.valid = 1'b1;
      d.out.data = ew;
    end
    // a block arrival and a length write in one cycle cancel out
    d.pend = q.pend + 10'(inc) - 10'(dec);
    if (sreset)
    begin
      d.ms = EBB_IDLE;
      d.hs = '0;
      d.cs = '0;
      d.ts = '0;
      d.tdone = 1'b0;
      d.cnt = '0;
      d.pend = '0;
      d.ack = 1'b0;
      d.out.valid = 1'b0;
    end
  end
  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.ctrl <= `EBB_CTRL_RST;
    end
    else if (ce)
      q <= d;
  end
endmodule // ebb_builder

// >>> ebb_builder_assertions.sv
// port checker for the event block builder
`timescale 1ns/1ps
module ebb_builder_chk
  import ebb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic net_full,
  input wire logic net_ready,
  input wire ebb_word_t net_out,
  input wire logic tb_ack
);
  // ======
  // register port
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_CTRL_READBACK:
  assert property (ce && reg_wr && reg_addr == 8'h00 ##1 !reg_wr ##1 ce && reg_rd &&
    reg_addr == 8'h00 |=> reg_rdata == ($past(reg_wdata, 3) & 32'h0000070F))
    else $error("control readback wrong");
  AST_RDATA_IDLE:
  assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero");
  AST_STATUS_CODES:
  assert property (ce && reg_rd && reg_addr == 8'h08 |=> reg_rdata[31:17] == 15'h0 &&
    reg_rdata[15:12] <= 4'h9 && reg_rdata[11:8] <= 4'h3 && reg_rdata[7:4] <= 4'h4 &&
    reg_rdata[3:0] <= 4'h3)
    else $error("status code out of range");
  AST_FULL_BIT:
  assert property (ce && reg_rd && reg_addr == 8'h08 |=> reg_rdata[16] == $past(net_full))
    else $error("backpressure bit wrong");
  AST_SYNC_STAT:
  assert property (ce && reg_rd && reg_addr == 8'h14 |=> reg_rdata[30:10] == 21'h0)
    else $error("sync data status shape");
  AST_SLEN_STAT:
  assert property (ce && reg_rd && reg_addr == 8'h1C |=>
    reg_rdata[30:26] == 5'h0 && reg_rdata[15:10] == 6'h0)
    else $error("sync length status shape");
  // ======
  // output stream
  AST_NO_EMIT_FULL:
  assert property (net_full && !net_out.valid |=> !net_out.valid)
    else $error("word emitted while full");
  AST_HOLD:
  assert property (net_out.valid && !net_ready |=> net_out.valid && $stable(net_out.data))
    else $error("word dropped before taken");
  AST_ACK_PULSE:
  assert property (tb_ack |=> !tb_ack)
    else $error("ack longer than one cycle");
endmodule // ebb_builder_chk

bind ebb_builder ebb_builder_chk u_ebb_builder_chk (.*);

// >>> ebb_far_model.sv
// far side model: trigger sources and network engine
`timescale 1ns/1ps
module ebb_far_model
  import ebb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic go,
  input wire logic [7:0] tb_n,
  input wire logic [7:0] fp_n,
  input wire logic full,
  output logic tb_len_valid,
  output logic [31:0] tb_len,
  input wire logic tb_len_ready,
  output ebb_word_t tb_word,
  input wire logic tb_word_ready,
  output logic fpga_len_valid,
  output logic [31:0] fpga_len,
  input wire logic fpga_len_ready,
  output ebb_word_t fpga_word,
  input wire logic fpga_word_ready,
  output logic net_full,
  output logic net_ready,
  input wire ebb_word_t net_out,
  input wire logic tb_ack,
  output logic [15:0] words,
  output logic [7:0] acks,
  output logic [31:0] last_word
);
  logic [7:0] tl_q;
  logic [7:0] fl_q;
  logic [31:0] cyc_q;
  // ======
  // idle lines move every cycle so stale data never matches
  assign tb_len = tb_len_valid ? {24'h0, tb_n} : cyc_q;
  assign fpga_len = fpga_len_valid ? {24'h0, fp_n} : ~cyc_q;
  assign tb_word = {tl_q != 8'h00, (tl_q != 8'h00) ? {24'h0, tl_q} : cyc_q};
  assign fpga_word = {fl_q != 8'h00, (fl_q != 8'h00) ? {24'h0, fl_q} : ~cyc_q};
  // engine stalls every other cycle, and for good while full
  assign net_full = full;
  assign net_ready = !full && cyc_q[0];
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tb_len_valid <= 1'b0;
      fpga_len_valid <= 1'b0;
      tl_q <= 8'h00;
      fl_q <= 8'h00;
      cyc_q <= 32'h0;
      words <= 16'h0;
      acks <= 8'h00;
      last_word <= 32'h0;
    end
    else
    begin
      cyc_q <= cyc_q + 32'h1;
      tb_len_valid <= go || (tb_len_valid && !tb_len_ready);
      fpga_len_valid <= go || (fpga_len_valid && !fpga_len_ready);
      if (tb_len_valid && tb_len_ready)
        tl_q <= tb_n;
      else if (tb_word.valid && tb_word_ready)
        tl_q <= tl_q - 8'h01;
      if (fpga_len_valid && fpga_len_ready)
        fl_q <= fp_n;
      else if (fpga_word.valid && fpga_word_ready)
        fl_q <= fl_q - 8'h01;
      words <= go ? 16'h0 : words + 16'(net_out.valid && net_ready);
      acks <= go ? 8'h00 : acks + 8'(tb_ack);
      // payload check point: the word most recently taken by the engine
      if (net_out.valid && net_ready)
        last_word <= net_out.data;
    end
  end
endmodule // ebb_far_model

// >>> testbench.sv
// self-checking bench for the event block builder
`timescale 1ns/1ps
module testbench
  import ebb_pkg::*;
;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic go = 1'b0;
  logic full = 1'b0;
  logic [7:0] tb_n = 8'h00;
  logic [7:0] fp_n = 8'h00;
  logic [31:0] reg_rdata, tb_len, fpga_len, rv;
  logic tb_len_valid, tb_len_ready, tb_word_ready, fpga_len_valid, fpga_len_ready;
  logic fpga_word_ready, net_full, net_ready, tb_ack, ddr_buffer_enable, ddr_dma_reset_n;
  ebb_word_t tb_word, fpga_word, net_out;
  logic [15:0] words;
  logic [31:0] last_word;
  logic [7:0] acks;
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h1C, 8'h24, 8'h2C, 8'h40};
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  always #12.5 ref_clk = ~ref_clk;
  ebb_builder u_ebb_builder (.*);
  ebb_far_model u_ebb_far_model (.*);
  // ======
  // tasks
  task automatic complete_run();
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    @(posedge ref_clk);
    chk(rv, e);
  endtask
  task automatic blk(input logic [7:0] t, input logic [7:0] f);
    tb_n <= t;
    fp_n <= f;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
  endtask
  task automatic wait_words(input logic [15:0] n);
    for (int k = 0; k < 600 && (acks == 8'h00 || words != n); k++)
      @(posedge ref_clk);
  endtask
  // ======
  // hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      complete_run();
    end
  end
  // ======
  // sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    foreach (ra[i])
      rc(ra[i], 32'h0);
    ce <= 1'b0;
    wr(8'h00, 32'h00000004);
    ce <= 1'b1;
    rc(8'h00, 32'h0);
    wr(8'h00, 32'hFFFFFFFF);
    rc(8'h00, 32'h0000070F);
    chk({ddr_buffer_enable, ddr_dma_reset_n}, 32'h2);
    wr(8'h00, 32'h0000000C);
    rc(8'h00, 32'h0000000C);
    chk({ddr_buffer_enable, ddr_dma_reset_n}, 32'h3);
    wr(8'h04, 32'h000001A5);
    rc(8'h04, 32'h000000A5);
    wr(8'h00, 32'h0);
    repeat (3) wr(8'h10, 32'h0000ABCD);
    rc(8'h14, 32'h00000003);
    wr(8'h18, 32'h00000003);
    rc(8'h1C, 32'h03FF0001);
    wr(8'h00, 32'h00000001);
    wr(8'h00, 32'h0);
    rc(8'h1C, 32'h0);
    repeat (513) wr(8'h10, 32'h00005A5A);
    rc(8'h14, 32'h80000200);
    wr(8'h00, 32'h00000001);
    wr(8'h00, 32'h00000100);
    rc(8'h14, 32'h0);
    blk(8'h02, 8'h03);
    wait_words(16'h0011);
    chk(words, 32'h00000011);
    chk(last_word, 32'h00000001);
    rc(8'h1C, 32'h00010000);
    wr(8'h00, 32'h0);
    blk(8'h01, 8'h05);
    wait_words(16'h000D);
    chk(words, 32'h0000000D);
    full <= 1'b1;
    wr(8'h00, 32'h00000200);
    blk(8'h00, 8'h00);
    repeat (40) @(posedge ref_clk);
    chk({acks, words}, 32'h0);
    // substates keep their last code between blocks; only the net header restarts
    rc(8'h08, 32'h00013303);
    wr(8'h10, 32'h11111111);
    wr(8'h18, 32'h00000002);
    wr(8'h10, 32'h22222222);
    repeat (20) @(posedge ref_clk);
    chk(words, 32'h0);
    rc(8'h08, 32'h00014303);
    full <= 1'b0;
    wait_words(16'h000E);
    chk(words, 32'h0000000E);
    chk(last_word, 32'h22222222);
    rc(8'h1C, 32'h00020000);
    wr(8'h00, 32'h00000002);
    blk(8'h00, 8'h00);
    repeat (40) @(posedge ref_clk);
    chk(words, 32'h0);
    wr(8'h00, 32'h0);
    wait_words(16'h000C);
    chk(words, 32'h0000000C);
    wr(8'h00, 32'h00000400);
    wr(8'h28, 32'h0);
    rc(8'h2C, 32'h0);
    wr(8'h20, 32'h0000A001);
    rc(8'h24, 32'h00000001);
    wr(8'h20, 32'h0000A002);
    wr(8'h28, 32'h00000002);
    for (int k = 0; k < 200 && words != 16'h000E; k++)
      @(posedge ref_clk);
    chk(words, 32'h0000000E);
    chk(last_word, 32'h0000A002);
    complete_run();
  end
endmodule // testbench
